// ---- rtl/bss_pkg.sv ----
package bss_pkg;
   // Register byte addresses
   localparam logic [7:0] BSS_OFF_STATUS = 8'h1C;
   localparam logic [7:0] BSS_OFF_CTRL = 8'h3C;
   localparam logic [7:0] BSS_OFF_EVT = 8'h40;
   localparam logic [7:0] BSS_OFF_MASK = 8'h44;
   // Secondary status bit positions within the 32-bit word
   localparam int BSS_B_CAP66 = 21;
   localparam int BSS_B_FB2B = 23;
   localparam int BSS_B_MDPE = 24;
   localparam int BSS_B_TIM_LO = 25;
   localparam int BSS_B_TIM_HI = 26;
   localparam int BSS_B_STA = 27;
   localparam int BSS_B_RTA = 28;
   localparam int BSS_B_RMA = 29;
   localparam int BSS_B_RSE = 30;
   localparam int BSS_B_DPE = 31;
   // Control word: parity error response enable
   localparam int BSS_B_PERR_EN = 16;
   // Timing field codes
   localparam logic [1:0] BSS_TIM_MEDIUM = 2'h1;
   localparam logic [1:0] BSS_TIM_NONE = 2'h0;
   // Flag slots in the event/mask registers (low bits)
   localparam int BSS_NFLAG = 6;
   localparam int BSS_F_MDPE = 0;
   localparam int BSS_F_STA = 1;
   localparam int BSS_F_RTA = 2;
   localparam int BSS_F_RMA = 3;
   localparam int BSS_F_RSE = 4;
   localparam int BSS_F_DPE = 5;
   // Bus response codes
   localparam logic [1:0] BSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] BSS_RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/bss_secondary_status.sv ----
`timescale 1ns/1ps
module bss_secondary_status
   import bss_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Bridge configuration straps
   input wire logic reverse_mode_i,
   input wire logic sec_pcix_mode_i,
   // Forward direction events (one-cycle pulses)
   input wire logic fwd_rd_parity_err_i,
   input wire logic fwd_wr_parity_fault_pin_i,
   input wire logic fwd_split_msg_parity_err_i,
   input wire logic fwd_target_abort_signaled_i,
   input wire logic fwd_target_abort_received_i,
   input wire logic fwd_master_abort_i,
   input wire logic fwd_system_fault_pin_i,
   input wire logic fwd_addr_data_parity_err_i,
   // Reverse direction events (one-cycle pulses)
   input wire logic rev_poisoned_cpl_i,
   input wire logic rev_poisoned_write_i,
   input wire logic rev_completer_abort_sent_i,
   input wire logic rev_completer_abort_rcvd_i,
   input wire logic rev_unsupported_cpl_i,
   input wire logic rev_err_msg_i,
   input wire logic rev_poisoned_tlp_i,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt and state outputs
   output logic irq_o,
   output logic perr_resp_en_o
);

   // Register words on the bus:
   //   status word - capability bits from the straps, sticky error flags in the top byte
   //   control word - parity response enable only
   //   event word - the same six events, kept for the interrupt, write one to clear
   //   mask word - one enable per event slot
   // Unmapped words answer with an error, and writes to them change nothing.
   // Reads have no side effects, so polling the status word is safe.

   // Flags in slot order
   logic [BSS_NFLAG-1:0] flags;
   logic [BSS_NFLAG-1:0] evt_sticky;
   logic [BSS_NFLAG-1:0] irq_mask;
   logic [BSS_NFLAG-1:0] next_set;
   logic perr_en;
   logic cap66;
   logic fb2b;
   logic [1:0] claim_timing;

   // Write channel holding state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic [BSS_NFLAG-1:0] w1c;
   logic [BSS_NFLAG-1:0] evt_w1c;

   // Byte lanes that gate each kind of write; a partial write that misses its lane is dropped
   localparam int BYTE_BITS = 8;
   localparam int LANE_FLAGS = 3;
   localparam int LANE_CTRL = 2;
   localparam int LANE_LOW = 0;

   // Elaboration checks: the slots must fit the low byte lane of the event and mask words
   if (BSS_NFLAG < 1 || BSS_NFLAG > BYTE_BITS) begin : g_bad_nflag
      $error("flag slot count must lie between one and eight");
   end
   // Every slot index must name a real slot
   if (BSS_F_MDPE >= BSS_NFLAG || BSS_F_STA >= BSS_NFLAG || BSS_F_RTA >= BSS_NFLAG ||
       BSS_F_RMA >= BSS_NFLAG || BSS_F_RSE >= BSS_NFLAG || BSS_F_DPE >= BSS_NFLAG) begin : g_bad_slot
      $error("flag slot index outside the slot range");
   end
   // Status flags must sit in the top byte, which only the top strobe reaches
   if (BSS_B_MDPE / BYTE_BITS != LANE_FLAGS || BSS_B_DPE / BYTE_BITS != LANE_FLAGS) begin : g_bad_pos
      $error("status flags must sit in the top byte lane");
   end
   // The enable must sit in the lane that its strobe guards
   if (BSS_B_PERR_EN / BYTE_BITS != LANE_CTRL) begin : g_bad_ctrl
      $error("parity enable must sit in the control byte lane");
   end
   // The claim timing field is two bits wide
   if (BSS_B_TIM_HI != BSS_B_TIM_LO + 1) begin : g_bad_tim
      $error("claim timing field must be two bits wide");
   end
   // Register words must be aligned, as the low address bits are dropped
   if (BSS_OFF_STATUS[1:0] != 2'h0 || BSS_OFF_CTRL[1:0] != 2'h0 ||
       BSS_OFF_EVT[1:0] != 2'h0 || BSS_OFF_MASK[1:0] != 2'h0) begin : g_bad_off
      $error("register offsets must be word aligned");
   end

   // Read-only capability bits follow the straps directly; they are not captured at reset
   // No storage: a strap that moved without a reset would show at once, so straps stay static
   assign cap66 = ~reverse_mode_i;
   assign fb2b = ~reverse_mode_i & ~sec_pcix_mode_i;
   assign claim_timing = reverse_mode_i ? BSS_TIM_NONE : BSS_TIM_MEDIUM;

   // Event decode per direction
   // Strobes of the idle direction are dropped, so a stray pulse cannot set a flag
   always_comb begin
      next_set = '0;
      if (!reverse_mode_i) begin
         next_set[BSS_F_MDPE] = perr_en & (fwd_rd_parity_err_i
            | fwd_wr_parity_fault_pin_i
            | fwd_split_msg_parity_err_i);
         next_set[BSS_F_STA] = fwd_target_abort_signaled_i;
         next_set[BSS_F_RTA] = fwd_target_abort_received_i;
         next_set[BSS_F_RMA] = fwd_master_abort_i;
         next_set[BSS_F_RSE] = fwd_system_fault_pin_i;
         next_set[BSS_F_DPE] = fwd_addr_data_parity_err_i;
      end else begin
         // Enable gates the poisoned-packet path in this direction
         next_set[BSS_F_MDPE] = perr_en & (rev_poisoned_cpl_i | rev_poisoned_write_i);
         next_set[BSS_F_STA] = rev_completer_abort_sent_i;
         next_set[BSS_F_RTA] = rev_completer_abort_rcvd_i;
         next_set[BSS_F_RMA] = rev_unsupported_cpl_i;
         next_set[BSS_F_RSE] = rev_err_msg_i;
         next_set[BSS_F_DPE] = rev_poisoned_tlp_i;
      end
   end

   // Map status word bits 31:27 and bit 24 onto flag slots
   function automatic logic [BSS_NFLAG-1:0] status_w1c(input logic [31:0] d,
                                                      input logic [3:0] s);
      logic [BSS_NFLAG-1:0] r;
      r = '0;
      r[BSS_F_MDPE] = s[LANE_FLAGS] & d[BSS_B_MDPE];
      r[BSS_F_STA] = s[LANE_FLAGS] & d[BSS_B_STA];
      r[BSS_F_RTA] = s[LANE_FLAGS] & d[BSS_B_RTA];
      r[BSS_F_RMA] = s[LANE_FLAGS] & d[BSS_B_RMA];
      r[BSS_F_RSE] = s[LANE_FLAGS] & d[BSS_B_RSE];
      r[BSS_F_DPE] = s[LANE_FLAGS] & d[BSS_B_DPE];
      return r;
   endfunction

   // A write commits once both address and data are held
   // The response term stops a held pair from committing twice while the answer waits
   assign wr_go = aw_held & w_held & ~s_axi_bvalid;
   assign w1c = (wr_go && aw_addr == BSS_OFF_STATUS) ? status_w1c(w_data, w_strb) : '0;
   assign evt_w1c = (wr_go && aw_addr == BSS_OFF_EVT && w_strb[LANE_LOW]) ?
                    w_data[BSS_NFLAG-1:0] : '0;

   // Sticky error flags; a same-cycle event beats the clear
   // Losing the race on the clear side means software never misses an event
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~w1c) | next_set;
      end
   end

   // Interrupt status: set on any new flag event, write-one clears
   // Kept apart from the flags so the interrupt can be acknowledged without losing the record
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_sticky <= '0;
      end else begin
         evt_sticky <= (evt_sticky & ~evt_w1c) | next_set;
      end
   end

   // Parity response enable; only a write that reaches its byte lane changes it
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         perr_en <= 1'b0;
      end else if (wr_go && aw_addr == BSS_OFF_CTRL && w_strb[LANE_CTRL]) begin
         perr_en <= w_data[BSS_B_PERR_EN];
      end
   end

   // Interrupt mask, same slot layout as the event status
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_mask <= '0;
      end else if (wr_go && aw_addr == BSS_OFF_MASK && w_strb[LANE_LOW]) begin
         irq_mask <= w_data[BSS_NFLAG-1:0];
      end
   end

   assign perr_resp_en_o = perr_en;

   // Level interrupt while any unmasked event bit stands
   // Built from registers only, so it cannot glitch on bus inputs
   assign irq_o = |(evt_sticky & irq_mask);

   // Write address and data are taken independently, held until the response
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;

   // Write address holder; released only by the response handshake
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && !aw_held) begin
         aw_held <= 1'b1;
         aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_held <= 1'b0;
      end
   end

   // Write data holder; the data may arrive before or after its address
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && !w_held) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_held <= 1'b0;
      end
   end

   // Known offsets reply OKAY, everything else SLVERR
   function automatic logic addr_known(input logic [7:0] a);
      return a == BSS_OFF_STATUS || a == BSS_OFF_CTRL ||
             a == BSS_OFF_EVT || a == BSS_OFF_MASK;
   endfunction

   // Write response valid: raised by the commit, dropped by the master's ready
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid <= 1'b0;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Write response code; an unmapped word answers an error
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bresp <= BSS_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bresp <= addr_known(aw_addr) ? BSS_RESP_OKAY : BSS_RESP_SLVERR;
      end
   end

   // Status word as read; reserved bits stay zero
   function automatic logic [31:0] status_word(input logic [BSS_NFLAG-1:0] f,
                                               input logic c66, input logic fb,
                                               input logic [1:0] tm);
      logic [31:0] w;
      w = '0;
      w[BSS_B_CAP66] = c66;
      w[BSS_B_FB2B] = fb;
      w[BSS_B_TIM_HI:BSS_B_TIM_LO] = tm;
      w[BSS_B_MDPE] = f[BSS_F_MDPE];
      w[BSS_B_STA] = f[BSS_F_STA];
      w[BSS_B_RTA] = f[BSS_F_RTA];
      w[BSS_B_RMA] = f[BSS_F_RMA];
      w[BSS_B_RSE] = f[BSS_F_RSE];
      w[BSS_B_DPE] = f[BSS_F_DPE];
      return w;
   endfunction

   // Read channel: one read at a time, data registered
   assign s_axi_arready = ~s_axi_rvalid;

   // Read valid: raised when the address is taken, dropped by the master's ready
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Read data and code, captured with the address and held until the answer is taken
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= BSS_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rresp <= BSS_RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'h0})
            BSS_OFF_STATUS: s_axi_rdata <= status_word(flags, cap66, fb2b, claim_timing);
            BSS_OFF_CTRL: s_axi_rdata <= 32'(perr_en) << BSS_B_PERR_EN;
            BSS_OFF_EVT: s_axi_rdata <= 32'(evt_sticky);
            BSS_OFF_MASK: s_axi_rdata <= 32'(irq_mask);
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= BSS_RESP_SLVERR;
            end
         endcase
      end
   end

endmodule

// ---- tb/bss_assertions.sv ----
`timescale 1ns/1ps
module bss_checker
   import bss_pkg::*;
(
   // Clock, reset and straps
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic reverse_mode_i,
   input wire logic sec_pcix_mode_i,
   // Register bus
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid
);
   logic [7:0] ra;
   logic st;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Address of the read in flight; arready stays low until it is answered
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) ra <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
   end
   // Status word on the read data lines
   assign st = s_axi_rvalid && ra == BSS_OFF_STATUS;
   sequence s_aw_w;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_cap66_bit: assert property (st |-> s_axi_rdata[21] == !reverse_mode_i)
      else $error("speed capability bit wrong");
   a_fb2b_bit: assert property (st |-> s_axi_rdata[23] == (!reverse_mode_i && !sec_pcix_mode_i))
      else $error("back to back capability bit wrong");
   a_timing_field: assert property (st |-> s_axi_rdata[26:25] ==
      (reverse_mode_i ? BSS_TIM_NONE : BSS_TIM_MEDIUM))
      else $error("claim timing field wrong");
   a_reserved_zero: assert property (st |-> s_axi_rdata[20:0] == 21'h0 && !s_axi_rdata[22])
      else $error("reserved status bits not zero");
   a_wr_answer: assert property (s_aw_w |=> s_resp)
      else $error("write response late or early");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while busy");
endmodule
bind bss_secondary_status bss_checker i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .reverse_mode_i(reverse_mode_i), .sec_pcix_mode_i(sec_pcix_mode_i),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid));

// ---- tb/bss_evt_model.sv ----
`timescale 1ns/1ps
module bss_evt_model (
   // Clock and request
   input wire logic ref_clk_i,
   input wire logic ev_go_i,
   input wire logic [3:0] ev_sel_i,
   // Event strobes: forward in 7:0, reverse in 14:8
   output logic [14:0] ev_o = 15'h0000
);
   // Core logic reports each event as a single-cycle strobe
   always_ff @(posedge ref_clk_i) begin
      ev_o <= 15'h0000;
      if (ev_go_i) ev_o[ev_sel_i] <= 1'b1;
   end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
   import bss_pkg::*;
();
   logic ref_clk_i, rst_i, reverse_mode_i, sec_pcix_mode_i, ev_go;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic irq_o, perr_resp_en_o;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb, ev_sel;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [14:0] ev;
   int err_total, checks;
   int bp[15] = '{24, 24, 24, 27, 28, 29, 30, 31, 24, 24, 27, 28, 29, 30, 31};
   // Event lines come from the core model, the rest by name
   bss_secondary_status i_dut (.*, .fwd_rd_parity_err_i(ev[0]), .fwd_wr_parity_fault_pin_i(ev[1]),
      .fwd_split_msg_parity_err_i(ev[2]), .fwd_target_abort_signaled_i(ev[3]),
      .fwd_target_abort_received_i(ev[4]), .fwd_master_abort_i(ev[5]),
      .fwd_system_fault_pin_i(ev[6]), .fwd_addr_data_parity_err_i(ev[7]),
      .rev_poisoned_cpl_i(ev[8]), .rev_poisoned_write_i(ev[9]), .rev_completer_abort_sent_i(ev[10]),
      .rev_completer_abort_rcvd_i(ev[11]), .rev_unsupported_cpl_i(ev[12]),
      .rev_err_msg_i(ev[13]), .rev_poisoned_tlp_i(ev[14]));
   bss_evt_model i_evt (.ref_clk_i(ref_clk_i), .ev_go_i(ev_go), .ev_sel_i(ev_sel), .ev_o(ev));
   // 100 ns clock
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   task automatic final_report();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait, judged at the falling edge so the rising edge is race free
   task automatic wt(input int k);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
         if (n > 50) begin
            err_total++;
            final_report();
         end
      end while (!(k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid
                   : k == 2 ? s_axi_arready : s_axi_rvalid));
      rdat = s_axi_rdata;
      rsp = k == 1 ? s_axi_bresp : s_axi_rresp;
      @(posedge ref_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wt(0);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wt(1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wt(2);
      s_axi_arvalid <= 1'b0;
      wt(3);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rst(input logic r, input logic p);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      reverse_mode_i <= r;
      sec_pcix_mode_i <= p;
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic ev_pulse(input int i);
      @(posedge ref_clk_i);
      ev_go <= 1'b1;
      ev_sel <= 4'(i);
      @(posedge ref_clk_i);
      ev_go <= 1'b0;
   endtask
   // Strap-dependent reset values, and read-only bits ignore writes
   task automatic t_straps();
      logic [31:0] e;
      for (int i = 0; i < 4; i++) begin
         e = {5'h00, i[1] ? 2'h0 : 2'h1, 1'b0, ~|i[1:0], 1'b0, ~i[1], 21'h0};
         rst(i[1], i[0]);
         rd(BSS_OFF_STATUS);
         chk(rdat, e);
         wr(BSS_OFF_STATUS, 32'hFFFF_FFFF);
         rd(BSS_OFF_STATUS);
         chk(rdat, e);
      end
   endtask
   // Each event sets its flag only in its own direction; zero write keeps it
   task automatic t_events(input logic r);
      rst(r, 1'b0);
      wr(BSS_OFF_CTRL, 32'h0001_0000);
      chk(perr_resp_en_o, 1'b1);
      for (int i = 0; i < 15; i++) begin
         if ((i > 7) != r) ev_pulse(i);
      end
      rd(BSS_OFF_STATUS);
      chk(rdat & 32'hF900_0000, 0);
      for (int i = 0; i < 15; i++) begin
         if ((i > 7) == r) begin
            ev_pulse(i);
            wr(BSS_OFF_STATUS, 32'h0000_0000);
            rd(BSS_OFF_STATUS);
            chk(rdat[bp[i]], 1'b1);
            wr(BSS_OFF_STATUS, 32'hFF00_0000);
            rd(BSS_OFF_STATUS);
            chk(rdat & 32'hF900_0000, 0);
         end
      end
   endtask
   // Enable off: parity flag held back, detected flag still set
   task automatic t_gate();
      rst(1'b1, 1'b0);
      ev_pulse(8);
      ev_pulse(14);
      rd(BSS_OFF_STATUS);
      chk(rdat[31:24], 8'h80);
      rst(1'b0, 1'b1);
      ev_pulse(0);
      ev_pulse(7);
      rd(BSS_OFF_STATUS);
      chk(rdat[31:24], 8'h82);
   endtask
   // Mask, raise and clear the interrupt; unmapped place refused
   task automatic t_irq();
      ev_pulse(3);
      chk(irq_o, 1'b0);
      wr(BSS_OFF_MASK, 32'h0000_0002);
      chk(rsp, BSS_RESP_OKAY);
      chk(irq_o, 1'b1);
      wr(BSS_OFF_EVT, 32'h0000_0002);
      chk(irq_o, 1'b0);
      rd(BSS_OFF_EVT);
      chk(rsp, BSS_RESP_OKAY);
      chk(rdat, 32'h0000_0020);
      rd(8'h80);
      chk(rsp, BSS_RESP_SLVERR);
      chk(rdat, 0);
      wr(8'h80, 32'hFFFF_FFFF);
      chk(rsp, BSS_RESP_SLVERR);
   endtask
   // Main sequence
   initial begin
      rst_i = 1'b1;
      {reverse_mode_i, sec_pcix_mode_i, ev_go, ev_sel, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      t_straps();
      t_events(1'b0);
      t_events(1'b1);
      t_gate();
      t_irq();
      final_report();
   end
endmodule
